// [verilog/adc_seq_map.vh]
// Register map, field positions and timing constants for the converter sequencer
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL     8'h00
`define OFS_THRESH   8'h04
`define OFS_READSEL  8'h08
`define OFS_RESULT_A 8'h0c
`define OFS_RESULT_B 8'h10
`define OFS_STATUS   8'h14

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define F_START     0
`define F_GROUP     1
`define F_SINGLE    2
`define F_CHAN_LO   4
`define F_CHAN_HI   6
`define F_TRIGIGN   7
`define F_DLYALL    8
`define F_PULSE8    9
`define F_PULSEEN   10
`define F_TS_LO     11
`define F_TS_HI     12
`define F_SENSE_LO  13
`define F_SENSE_HI  14
`define F_DLY_LO    16
`define F_DLY_HI    20
`define F_CTX2      23
`define CTRL_RESET  24'h000000
`define THRESH_RESET 10'h3ff

// Touch readout modes
`define TS_OFF      2'h0
`define TS_PEN      2'h1
`define TS_RESIST   2'h2
`define TS_POS      2'h3

// Plate drive configurations
`define PL_IDLE     3'h0
`define PL_PEN      3'h1
`define PL_XPLATE   3'h2
`define PL_YPLATE   3'h3
`define PL_CONTACT  3'h4
`define PL_XPOS     3'h5
`define PL_YPOS     3'h6

// Touch channels
`define CH_XPLATE   4'hc
`define CH_YPLATE   4'he

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ       250
`define DLY_UNIT_US   500
`define DLY_UNIT_CYCLES (`DLY_UNIT_US * `CLK_MHZ)
`define DLY_MAX_CODE  5'h10

`endif

// [verilog/adc_sequencer_control.v]
// Sequencer, context arbitration and register slave around one 10-bit converter core
`timescale 1ns/1ps
`include "adc_seq_map.vh"

module adc_sequencer_control #(
	parameter DELAY_UNIT_CYCLES = `DLY_UNIT_CYCLES
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// AXI4-Lite write channels
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output wire        awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	// AXI4-Lite read channels
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output wire        arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	// External trigger
	input  wire        externalTriggerInput,
	// Converter core
	output reg         convStart,
	output reg  [3:0]  convChannel,
	input  wire [9:0]  convResult,
	input  wire        convDone,
	// Analog front-end controls
	output reg         thermistorBiasEn,
	output reg  [1:0]  sharedSenseSel,
	output reg  [2:0]  plateCfg,
	input  wire        penContact,
	// Events and pulse
	output reg         conversionPulseOutput,
	output reg         doneOwner,
	output reg         doneOther,
	output reg         penIrq
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WAIT = 2'h1;
	localparam [1:0] ST_CONV = 2'h2;
	localparam [31:0] UNIT_LAST = DELAY_UNIT_CYCLES - 1;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Byte-lane merge for register writes
	function [31:0] mergeStrb;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer k;
		begin
			mergeStrb = old;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					mergeStrb[k*8 +: 8] = data[k*8 +: 8];
		end
	endfunction

	// Delay code limited to the 8 ms ceiling
	function [4:0] clampDly;
		input [23:0] c;
		begin
			if (c[`F_DLY_HI:`F_DLY_LO] > `DLY_MAX_CODE)
				clampDly = `DLY_MAX_CODE;
			else
				clampDly = c[`F_DLY_HI:`F_DLY_LO];
		end
	endfunction

	// Channel for step i of a series
	function [3:0] chanFor;
		input [23:0] c;
		input [2:0]  i;
		begin
			case (c[`F_TS_HI:`F_TS_LO])
				`TS_RESIST: chanFor = (i < 3'h3) ? `CH_XPLATE : (i < 3'h6) ? `CH_YPLATE : `CH_XPLATE;
				`TS_POS:    chanFor = (i < 3'h3) ? `CH_YPLATE : `CH_XPLATE;
				default:    chanFor = c[`F_SINGLE] ? {c[`F_GROUP], c[`F_CHAN_HI:`F_CHAN_LO]}
				                                   : {c[`F_GROUP], i};
			endcase
		end
	endfunction

	// Plate drive for step i of a series
	function [2:0] plateFor;
		input [23:0] c;
		input [2:0]  i;
		begin
			case (c[`F_TS_HI:`F_TS_LO])
				`TS_RESIST: plateFor = (i < 3'h3) ? `PL_XPLATE : (i < 3'h6) ? `PL_YPLATE : `PL_CONTACT;
				`TS_POS:    plateFor = (i < 3'h3) ? `PL_XPOS : (i < 3'h6) ? `PL_YPOS : `PL_CONTACT;
				default:    plateFor = `PL_IDLE;
			endcase
		end
	endfunction

	// Address decode shared by both bus directions; results are read-only
	function addrOk;
		input [7:0] a;
		input       isWrite;
		begin
			case (a)
				`OFS_CTRL, `OFS_THRESH, `OFS_READSEL, `OFS_STATUS: addrOk = 1'b1;
				`OFS_RESULT_A, `OFS_RESULT_B:                      addrOk = ~isWrite;
				default:                                           addrOk = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg        awHaveReg;
	reg [7:0]  awAddrReg;
	reg        wHaveReg;
	reg [31:0] wDataReg;
	reg [3:0]  wStrbReg;
	reg [23:0] ctx0Reg;
	reg [23:0] ctx1Reg;
	reg [23:0] actReg;
	reg        actCtxReg;
	reg [1:0]  pendReg;
	reg [1:0]  stateReg;
	reg [2:0]  idxReg;
	reg [16:0] unitCntReg;
	reg [4:0]  dlyLeftReg;
	reg [9:0]  threshReg;
	reg        aboveReg;
	reg [5:0]  readSelReg;
	reg        trigPrevReg;
	reg        penPrevReg;
	reg [9:0]  resultMem [0:7];
	reg [31:0] readMux;
	integer    n;

	wire        doWrite  = awHaveReg & wHaveReg;
	wire [2:0]  selA     = readSelReg[2:0];
	wire [2:0]  selB     = readSelReg[5:3];
	wire [2:0]  selA1    = selA + 3'h1;
	wire [2:0]  selB1    = selB + 3'h1;
	wire        trigRise = externalTriggerInput & ~trigPrevReg;
	wire [31:0] ctrlNew  = mergeStrb({8'h00, ctx0Reg}, wDataReg, wStrbReg);
	wire [31:0] threshNew = mergeStrb({22'h000000, threshReg}, wDataReg, wStrbReg);
	wire        toCtx2   = ctrlNew[`F_CTX2] & wStrbReg[2];
	wire        wrCtrl   = doWrite && awAddrReg == `OFS_CTRL;
	wire        wrStat   = doWrite && awAddrReg == `OFS_STATUS;
	wire        aboveNow = convDone && stateReg == ST_CONV && convResult > threshReg;

	// Write accepts only while no response is outstanding
	assign awready = ~awHaveReg & ~bvalid;
	assign wready  = ~wHaveReg & ~bvalid;
	assign arready = ~rvalid;

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	// Queued context is write-only; its steering bit never shows
	always @* begin
		case (araddr)
			`OFS_CTRL:     readMux = {8'h00, 1'b0, ctx0Reg[22:1], 1'b0};
			`OFS_THRESH:   readMux = {22'h000000, threshReg};
			`OFS_READSEL:  readMux = {26'h0000000, readSelReg};
			`OFS_RESULT_A: readMux = {12'h000, resultMem[selA1], resultMem[selA]};
			`OFS_RESULT_B: readMux = {12'h000, resultMem[selB1], resultMem[selB]};
			`OFS_STATUS:   readMux = {22'h000000, penContact, aboveReg, idxReg, pendReg, actCtxReg, stateReg};
			default:       readMux = 32'h00000000;
		endcase
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	// Address and data latch independently; the write lands one edge after both are held
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			awHaveReg <= 1'b0;
			awAddrReg <= 8'h00;
			wHaveReg  <= 1'b0;
			wDataReg  <= 32'h00000000;
			wStrbReg  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= 2'h0;
			rvalid    <= 1'b0;
			rresp     <= 2'h0;
			rdata     <= 32'h00000000;
		end else begin
			if (awvalid && awready) begin
				awHaveReg <= 1'b1;
				awAddrReg <= awaddr;
			end
			if (wvalid && wready) begin
				wHaveReg <= 1'b1;
				wDataReg <= wdata;
				wStrbReg <= wstrb;
			end
			if (doWrite) begin
				awHaveReg <= 1'b0;
				wHaveReg  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= addrOk(awAddrReg, 1'b1) ? 2'h0 : 2'h2;
			end else if (bvalid && bready)
				bvalid <= 1'b0;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata  <= readMux;
				rresp  <= addrOk(araddr, 1'b0) ? 2'h0 : 2'h2;
			end else if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Bit 23 steers the whole word to the queued context
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ctx0Reg    <= `CTRL_RESET;
			ctx1Reg    <= `CTRL_RESET;
			threshReg  <= `THRESH_RESET;
			readSelReg <= 6'h00;
		end else if (doWrite) begin
			if (wrCtrl && toCtx2)
				ctx1Reg <= {1'b0, ctrlNew[22:1], 1'b0};
			else if (wrCtrl)
				ctx0Reg <= {1'b0, ctrlNew[22:1], 1'b0};
			if (awAddrReg == `OFS_THRESH)
				threshReg <= threshNew[9:0];
			if (awAddrReg == `OFS_READSEL)
				readSelReg <= wStrbReg[0] ? wDataReg[5:0] : readSelReg;
		end
	end

	// ----------------------------------------
	// Start requests and threshold flag
	// ----------------------------------------
	// Dispatch clears a pending bit, but a new start in that cycle wins
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pendReg     <= 2'h0;
			trigPrevReg <= 1'b0;
			aboveReg    <= 1'b0;
		end else begin
			trigPrevReg <= externalTriggerInput;
			if (stateReg == ST_IDLE && pendReg[0])
				pendReg[0] <= 1'b0;
			else if (stateReg == ST_IDLE && pendReg[1])
				pendReg[1] <= 1'b0;
			if (trigRise && !ctx0Reg[`F_TRIGIGN])
				pendReg[0] <= 1'b1;
			if (wrCtrl && ctrlNew[`F_START] && wStrbReg[0])
				pendReg[toCtx2] <= 1'b1;
			if (wrStat && wStrbReg[1] && wDataReg[8])
				aboveReg <= 1'b0;
			if (aboveNow)
				aboveReg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	// Owner context wins a tie; a running series is never cut short
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stateReg              <= ST_IDLE;
			actReg                <= `CTRL_RESET;
			actCtxReg             <= 1'b0;
			idxReg                <= 3'h0;
			unitCntReg            <= 17'h00000;
			dlyLeftReg            <= 5'h00;
			convStart             <= 1'b0;
			convChannel           <= 4'h0;
			thermistorBiasEn      <= 1'b0;
			conversionPulseOutput <= 1'b0;
			doneOwner             <= 1'b0;
			doneOther             <= 1'b0;
			for (n = 0; n < 8; n = n + 1)
				resultMem[n] <= 10'h000;
		end else begin
			convStart <= 1'b0;
			doneOwner <= 1'b0;
			doneOther <= 1'b0;
			case (stateReg)
				ST_IDLE: begin
					if (pendReg != 2'h0) begin
						actCtxReg        <= ~pendReg[0];
						actReg           <= pendReg[0] ? ctx0Reg : ctx1Reg;
						dlyLeftReg       <= clampDly(pendReg[0] ? ctx0Reg : ctx1Reg);
						unitCntReg       <= 17'h00000;
						idxReg           <= 3'h0;
						thermistorBiasEn <= 1'b1;
						stateReg         <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (dlyLeftReg == 5'h00) begin
						convStart   <= 1'b1;
						convChannel <= chanFor(actReg, idxReg);
						if (idxReg == 3'h0 && actReg[`F_PULSEEN])
							conversionPulseOutput <= 1'b1;
						stateReg <= ST_CONV;
					end else if (unitCntReg == UNIT_LAST[16:0]) begin
						unitCntReg <= 17'h00000;
						dlyLeftReg <= dlyLeftReg - 5'h01;
					end else
						unitCntReg <= unitCntReg + 17'h00001;
				end
				ST_CONV: begin
					if (convDone) begin
						resultMem[idxReg] <= convResult;
						if (idxReg == 3'h7 || (idxReg == 3'h3 && !actReg[`F_PULSE8]))
							conversionPulseOutput <= 1'b0;
						// Last step frees the core and tells only the starting context
						if (idxReg == 3'h7) begin
							doneOwner        <= ~actCtxReg;
							doneOther        <= actCtxReg;
							thermistorBiasEn <= 1'b0;
							stateReg         <= ST_IDLE;
						end else begin
							idxReg     <= idxReg + 3'h1;
							unitCntReg <= 17'h00000;
							dlyLeftReg <= actReg[`F_DLYALL] ? clampDly(actReg) : 5'h00;
							stateReg   <= ST_WAIT;
						end
					end
				end
				default: stateReg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Front-end control and pen detect
	// ----------------------------------------
	// Pen detect runs only while idle in pen mode; the converter stays untouched
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			plateCfg       <= `PL_IDLE;
			sharedSenseSel <= 2'h0;
			penPrevReg     <= 1'b0;
			penIrq         <= 1'b0;
		end else begin
			penPrevReg <= penContact;
			penIrq     <= 1'b0;
			if (stateReg != ST_IDLE) begin
				plateCfg       <= plateFor(actReg, idxReg);
				sharedSenseSel <= actReg[`F_SENSE_HI:`F_SENSE_LO];
			end else begin
				sharedSenseSel <= ctx0Reg[`F_SENSE_HI:`F_SENSE_LO];
				if (ctx0Reg[`F_TS_HI:`F_TS_LO] == `TS_PEN) begin
					plateCfg <= `PL_PEN;
					penIrq   <= penContact & ~penPrevReg & (pendReg == 2'h0);
				end else
					plateCfg <= `PL_IDLE;
			end
		end
	end

endmodule // adc_sequencer_control

// [testbench/conv_core_model.sv]
// Behavioural converter core answering each start after a short or a long wait
`timescale 1ns/1ps

module conv_core_model (
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	// Converter handshake
	input  wire       convStart,
	input  wire [3:0] convChannel,
	output reg  [9:0] convResult,
	output reg        convDone
);
	reg [3:0] waitReg;
	reg [3:0] chanReg;
	reg       slowReg;

	// Alternate prompt and slow answers; result toggles outside done so stale data equals the last answer only every other cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			waitReg    <= 4'h0;
			chanReg    <= 4'h0;
			slowReg    <= 1'b0;
			convDone   <= 1'b0;
			convResult <= 10'h2aa;
		end else begin
			convDone   <= 1'b0;
			convResult <= ~convResult;
			if (convStart) begin
				chanReg <= convChannel;
				waitReg <= slowReg ? 4'h9 : 4'h2;
				slowReg <= ~slowReg;
			end else if (waitReg == 4'h1) begin
				convDone   <= 1'b1;
				convResult <= {chanReg, 6'h15};
				waitReg    <= 4'h0;
			end else if (waitReg != 4'h0) begin
				waitReg <= waitReg - 4'h1;
			end
		end
	end
endmodule // conv_core_model

// [testbench/adc_seq_properties.sv]
// Port-level checker for the converter sequencer
`timescale 1ns/1ps

module adc_seq_properties (
	// Clock and reset
	input wire        clk,
	input wire        rst,
	// Register bus
	input wire        awready,
	input wire        wready,
	input wire        bvalid,
	input wire        bready,
	input wire [1:0]  bresp,
	input wire        arready,
	input wire        rvalid,
	input wire        rready,
	input wire [31:0] rdata,
	// Sequencer outputs
	input wire        convStart,
	input wire        thermistorBiasEn,
	input wire        conversionPulseOutput,
	input wire        doneOwner,
	input wire        doneOther,
	input wire        penIrq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Converter handshake and series events
	a_start_one_cycle: assert property (convStart |=> !convStart) else $error("start wider than one cycle");
	a_bias_before_start: assert property (convStart |-> $past(thermistorBiasEn)) else $error("start unbiased");
	a_pulse_rise_start: assert property ($rose(conversionPulseOutput) |-> convStart) else $error("pulse off sync");
	a_done_one_owner: assert property (!(doneOwner && doneOther)) else $error("both contexts notified");
	a_done_short: assert property ((doneOwner || doneOther) |=> !(doneOwner || doneOther)) else $error("done wide");
	a_pen_no_core: assert property (penIrq |-> !convStart && !thermistorBiasEn) else $error("pen used core");
	// Bus answers hold and block new requests
	a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
	a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata dropped");
	a_write_refused: assert property (bvalid |-> !awready && !wready) else $error("write taken during response");
	a_read_refused: assert property (rvalid |-> !arready) else $error("read taken during response");
endmodule // adc_seq_properties

bind adc_sequencer_control adc_seq_properties u_adc_seq_properties (.clk(clk), .rst(rst), .awready(awready),
	.wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arready(arready), .rvalid(rvalid),
	.rready(rready), .rdata(rdata), .convStart(convStart), .thermistorBiasEn(thermistorBiasEn),
	.conversionPulseOutput(conversionPulseOutput), .doneOwner(doneOwner), .doneOther(doneOther), .penIrq(penIrq));

// [testbench/tb.sv]
// Register-level testbench for the converter sequencer
`timescale 1ns/1ps
`include "adc_seq_map.vh"

module tb;
	reg         clk, rst, awvalid, wvalid, bready, arvalid, rready, externalTriggerInput, penContact, statClr;
	reg  [7:0]  awaddr, araddr;
	reg  [31:0] wdata, rdv;
	reg  [1:0]  rsv, bsv;
	wire        awready, wready, bvalid, arready, rvalid, convStart, convDone, thermistorBiasEn;
	wire        conversionPulseOutput, doneOwner, doneOther, penIrq;
	wire [1:0]  bresp, rresp, sharedSenseSel;
	wire [31:0] rdata;
	wire [3:0]  convChannel;
	wire [9:0]  convResult;
	wire [2:0]  plateCfg;
	integer     nMismatch, testsRun, o, q, t;
	integer     nOwn = 0, nOth = 0, nStart = 0, nPen = 0, pulseDone = 0, gap = 0, minGap = 999, ownAtOther = 0;

	// ----------------------------------------
	// Design, core model and clock
	// ----------------------------------------
	adc_sequencer_control #(.DELAY_UNIT_CYCLES(4)) u_adc_sequencer_control (.clk(clk), .rst(rst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.externalTriggerInput(externalTriggerInput), .convStart(convStart), .convChannel(convChannel),
		.convResult(convResult), .convDone(convDone), .thermistorBiasEn(thermistorBiasEn),
		.sharedSenseSel(sharedSenseSel), .plateCfg(plateCfg), .penContact(penContact),
		.conversionPulseOutput(conversionPulseOutput), .doneOwner(doneOwner), .doneOther(doneOther), .penIrq(penIrq));
	conv_core_model u_conv_core_model (.clk(clk), .rst(rst), .convStart(convStart), .convChannel(convChannel),
		.convResult(convResult), .convDone(convDone));
	always #2 clk = ~clk;

	// Event monitor; gap counts edges since the last converter answer
	always @(posedge clk) begin
		if (statClr === 1'b1) begin
			pulseDone <= 0;
			minGap    <= 999;
		end else begin
			if (convStart === 1'b1 && gap < minGap)
				minGap <= gap;
			if (convDone === 1'b1 && conversionPulseOutput === 1'b1)
				pulseDone <= pulseDone + 1;
		end
		if (convStart === 1'b1)
			nStart <= nStart + 1;
		gap <= (convDone === 1'b1) ? 0 : gap + 1;
		if (doneOwner === 1'b1)
			nOwn <= nOwn + 1;
		if (doneOther === 1'b1) begin
			nOth       <= nOth + 1;
			ownAtOther <= nOwn;
		end
		if (penIrq === 1'b1)
			nPen <= nPen + 1;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task printVerdict;
		begin
			$display("comparisons %0d mismatches %0d", testsRun, nMismatch);
			if (nMismatch == 0 && testsRun > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask

	task chk(input [8*8-1:0] name, input [31:0] exp, input [31:0] got);
		begin
			testsRun = testsRun + 1;
			if (got !== exp) begin
				nMismatch = nMismatch + 1;
				$display("BAD %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask

	// Ready is raised only once the answer shows, so the hold checks see a waiting response
	task wr(input [7:0] a, input [31:0] d);
		integer k;
		begin
			@(posedge clk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			for (k = 0; k < 200 && !(bvalid === 1'b1 && bready === 1'b1); k = k + 1) begin
				@(posedge clk);
				if (awvalid === 1'b1 && awready === 1'b1)
					awvalid <= 1'b0;
				if (wvalid === 1'b1 && wready === 1'b1)
					wvalid <= 1'b0;
				if (bvalid === 1'b1) begin
					bready <= ~bready;
					bsv = bresp;
				end
			end
			if (k == 200)
				begin nMismatch = nMismatch + 1; printVerdict; end
		end
	endtask

	task rd(input [7:0] a);
		integer k;
		begin
			@(posedge clk);
			araddr <= a;
			arvalid <= 1'b1;
			for (k = 0; k < 200 && !(rvalid === 1'b1 && rready === 1'b1); k = k + 1) begin
				@(posedge clk);
				if (arvalid === 1'b1 && arready === 1'b1)
					arvalid <= 1'b0;
				if (rvalid === 1'b1) begin
					rready <= ~rready;
					rdv = rdata;
					rsv = rresp;
				end
			end
			if (k == 200)
				begin nMismatch = nMismatch + 1; printVerdict; end
		end
	endtask

	// Waits for the addressed context's series; ex holds the expected channel of step i in nibble i
	task run(input [31:0] c, input [31:0] ex);
		integer i;
		begin
			o = c[`F_CTX2] ? nOth : nOwn;
			statClr <= 1'b1;
			wr(`OFS_CTRL, c);
			statClr <= 1'b0;
			for (t = 0; t < 3000 && (c[`F_CTX2] ? nOth : nOwn) == o; t = t + 1)
				@(posedge clk);
			if ((c[`F_CTX2] ? nOth : nOwn) == o)
				begin nMismatch = nMismatch + 1; printVerdict; end
			for (i = 0; i < 8; i = i + 2) begin
				wr(`OFS_READSEL, i | ((i + 1) << 3));
				rd(`OFS_RESULT_A);
				chk("resA", {12'h0, ex[4*(i+1)+:4], 6'h15, ex[4*i+:4], 6'h15}, rdv);
				rd(`OFS_RESULT_B);
				chk("resB", {12'h0, ex[4*((i+2)%8)+:4], 6'h15, ex[4*(i+1)+:4], 6'h15}, rdv);
			end
		end
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{clk, awvalid, wvalid, bready, arvalid, rready, externalTriggerInput, penContact, statClr} = 9'h000;
		{awaddr, araddr, wdata} = 48'h0;
		nMismatch = 0;
		testsRun = 0;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(`OFS_THRESH); chk("thresh", 32'h3ff, rdv);
		rd(8'h40); chk("rdErr", 32'h2, rsv); chk("rdZero", 32'h0, rdv);
		wr(8'h40, 32'h0); chk("wrErr", 32'h2, bsv);
		run(32'h603, 32'hfedcba98); chk("pulse8", 8, pulseDone);
		run(32'h455, 32'h55555555); chk("pulse4", 4, pulseDone);
		run(32'h1801, 32'hccccceee);
		run(32'h1001, 32'hcceeeccc);
		wr(`OFS_THRESH, 32'h0); chk("wrOk", 32'h0, bsv);
		run(32'h20101, 32'h76543210); chk("gapDly", 1, minGap >= 8);
		run(32'h20001, 32'h76543210); chk("gapNone", 1, minGap < 8);
		rd(`OFS_STATUS); chk("above", 1, rdv[8]);
		wr(`OFS_STATUS, 32'h100);
		rd(`OFS_STATUS); chk("aboveClr", 0, rdv[8]);
		// Trigger edge starts a series, then is ignored
		wr(`OFS_CTRL, 32'h2);
		o = nOwn;
		externalTriggerInput <= 1'b1;
		for (t = 0; t < 3000 && nOwn == o; t = t + 1)
			@(posedge clk);
		chk("trigRun", o + 1, nOwn);
		externalTriggerInput <= 1'b0;
		wr(`OFS_CTRL, 32'h82);
		o = nStart;
		externalTriggerInput <= 1'b1;
		repeat (100) @(posedge clk);
		chk("trigIgn", o, nStart);
		// Queued request written while the owner series runs
		q = nOwn;
		wr(`OFS_CTRL, 32'h1);
		run(32'h800003, 32'hfedcba98);
		chk("ownFirst", q + 1, ownAtOther);
		chk("ownOnce", q + 1, nOwn);
		rd(`OFS_CTRL); chk("ctrlRd", 32'h0, rdv);
		// Channel 7 source and pen detection
		wr(`OFS_CTRL, 32'h4800);
		repeat (3) @(posedge clk);
		chk("sense", 2, sharedSenseSel);
		chk("plate", 1, plateCfg);
		o = nPen;
		penContact <= 1'b1;
		repeat (5) @(posedge clk);
		chk("penIrq", o + 1, nPen);
		printVerdict;
	end
endmodule // tb
